// file: rff_frame_filter.sv
// Receive frame type filter: APB registers, header capture and accept decision.
// Assumes the octet stream is produced on pclk by the demodulator, so it is
// not synchronised, and an APB master that follows the usual two-phase protocol.
// Verdicts appear as pulses two edges after the final octet of a frame.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1: Coordinator behaviour only acts while the master filter enable is set.
// R2: Coordinator accepts a frame without destination if source network id matches.
// R3: Ordinary node rejects a frame whose destination address is not its own.
// R4: Coordinator-select bit one gives coordinator rules, zero gives ordinary node rules.
// R5: Beacon frames pass only with the beacon allow bit and the other checks.
// R6: Data frames pass only with the data allow bit and the other checks.
// R7: Acknowledgment frames pass only with the ack allow bit and other checks.
// R8: Command frames pass only with the command allow bit and other checks.
// R9: Reserved-types allow accepts types four to seven without address matching.
// R10: Without reserved allow, reserved types drop unless type four or five allowed.
// R11: Every filtered frame shorter than its frame control minimum length is rejected.
// R12: Type-four allow accepts type four frames without address matching.
// R13: Type four frames drop when neither type-four nor reserved allow is set.
// R14: Known types also need every address check to pass.
// R15: The master enable turns all type and address filtering on or off.
// R16: Network identifier and short address reset to all ones.
// R17: Type-five allow accepts type five; else dropped unless reserved allowed.
// R18: A frame failing any check is discarded, not reported as good.
// R19: Software programs addresses and options before setting the master enable.
module rff_frame_filter #(
    parameter int unsigned LEN_W = 11,
    parameter int unsigned CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rff_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic rx_good,
    output logic rx_drop,
    output logic [1:0] rx_drop_why
);
    import rff_pkg::*;

    // Shortest frame, checksum included, that the frame control field allows.
    function automatic logic [7:0] min_len(input logic [15:0] ctl);
        logic src_id_in;
        src_id_in = ctl[FCF_SM+1] && !(ctl[FCF_PANC] && ctl[FCF_DM+1]);
        min_len = src_pan_pos(ctl) + (src_id_in ? PAN_LEN : 8'h00) + addr_len(ctl[FCF_SM+:2]) + FCS_LEN;
    endfunction : min_len

    // Byte-lane merge of APB write data under the strobes.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                merge[8*i+:8] = wd[8*i+:8];
            end
        end
    endfunction : merge

    typedef struct packed {
        logic [CFG_W-1:0] cfg;
        logic [15:0] net_id;
        logic [15:0] short_addr;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        rff_judge_t state;
        logic seen;
        logic last_ok;
        logic [2:0] last_type;
        logic [1:0] last_why;
        logic [LEN_W-1:0] last_len;
        logic [CNT_W-1:0] good_cnt;
        logic [CNT_W-1:0] drop_cnt;
        logic good;
        logic drop;
        logic [1:0] why;
    } rff_state_t;

    rff_state_t s_q;
    rff_state_t s_d;

    logic [15:0] fcf;
    logic [15:0] dst_pan;
    logic [15:0] dst_short;
    logic [15:0] src_pan;
    logic [LEN_W-1:0] count;

    // Header capture runs beside the decision logic on the same octets.
    rff_hdr_parse #(
        .LEN_W(LEN_W)
    ) u_parse (
        .pclk(pclk),
        .presetn(presetn),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .rx_last(rx_last),
        .fcf(fcf),
        .dst_pan(dst_pan),
        .dst_short(dst_short),
        .src_pan(src_pan),
        .count(count)
    );

    // Decoded view of the captured header.
    logic [2:0] ftype;
    logic [1:0] dmode;
    logic [1:0] smode;
    logic [15:0] src_pan_eff;
    logic filt_on;
    logic coord;
    logic len_ok;
    logic pan_ok;
    logic short_ok;
    logic addr_ok;
    logic type_ok;
    logic accept;
    logic [1:0] why;

    assign ftype = fcf[2:0];
    assign dmode = fcf[FCF_DM+:2];
    assign smode = fcf[FCF_SM+:2];

    // With compression the source network id is carried by the destination field.
    assign src_pan_eff = (fcf[FCF_PANC] && dmode[1]) ? dst_pan : src_pan;

    // Filtering as a whole, and coordinator behaviour inside it.
    assign filt_on = s_q.cfg[CFG_EN]; // R15
    assign coord = filt_on && s_q.cfg[CFG_COORD]; // R1 R4

    // Minimum length comes from the frame control field for every type.
    assign len_ok = count >= LEN_W'(min_len(fcf)); // R11

    // Destination matches the own identifiers or the broadcast value.
    assign pan_ok = (dst_pan == s_q.net_id) || (dst_pan == BCAST);
    assign short_ok = (dst_short == s_q.short_addr) || (dst_short == BCAST);

    // Address checks for the four known frame types.
    always_comb begin
        // Long destination addresses never match; none is held here.
        addr_ok = 1'b0;

        if (dmode == AM_SHORT) begin
            // Both destination fields must be our own or broadcast.
            addr_ok = pan_ok && short_ok; // R3
        end else if (dmode == AM_NONE) begin
            // An acknowledgment without addresses needs no further check.
            if (ftype == FT_ACK && smode == AM_NONE) begin
                addr_ok = 1'b1;
            end else if (coord) begin
                // A coordinator takes frames from inside its own network.
                addr_ok = smode[1] && (src_pan_eff == s_q.net_id); // R2
            end else if (ftype == FT_BEACON) begin
                // A node hears its network's beacons, or every beacon while unassigned.
                addr_ok = (src_pan_eff == s_q.net_id) || (s_q.net_id == BCAST);
            end
        end
    end

    // Type gate: known types also need addresses, reserved types skip them.
    always_comb begin
        type_ok = 1'b0;
        unique case (ftype)
            FT_BEACON: begin
                type_ok = s_q.cfg[CFG_BCN]; // R5
            end
            FT_DATA: begin
                type_ok = s_q.cfg[CFG_DATA]; // R6
            end
            FT_ACK: begin
                type_ok = s_q.cfg[CFG_ACK]; // R7
            end
            FT_CMD: begin
                type_ok = s_q.cfg[CFG_CMD]; // R8
            end
            FT_RES4: begin
                type_ok = s_q.cfg[CFG_T4] || s_q.cfg[CFG_RES]; // R12 R13 R10
            end
            FT_RES5: begin
                type_ok = s_q.cfg[CFG_T5] || s_q.cfg[CFG_RES]; // R17 R10
            end
            default: begin
                type_ok = s_q.cfg[CFG_RES]; // R9 R10
            end
        endcase
    end

    // Final verdict and the first failing check, in type, address, length order.
    always_comb begin
        accept = 1'b1;
        why = WHY_NONE;

        // With filtering off every frame is good, whatever its length.
        if (filt_on) begin
            if (!type_ok) begin
                accept = 1'b0;
                why = WHY_TYPE;
            end else if (!ftype[2] && !addr_ok) begin
                accept = 1'b0; // R14
                why = WHY_ADDR;
            end else if (!len_ok) begin
                accept = 1'b0; // R11
                why = WHY_LEN;
            end
        end
    end

    // APB decode of the setup phase.
    logic setup;
    logic wr_now;
    logic hit;
    logic [31:0] rd_val;
    logic [31:0] cfg_word;
    logic [31:0] addr_word;
    logic [31:0] status_word;
    logic [31:0] count_word;

    assign setup = psel && !penable;
    // A write lands at the access edge, and only when no error was answered.
    assign wr_now = psel && penable && s_q.pready && pwrite && !s_q.pslverr;
    assign cfg_word = {{(32-CFG_W){1'b0}}, s_q.cfg};
    assign addr_word = {s_q.net_id, s_q.short_addr};

    // Last verdict: valid, accepted, type, reason, and the frame length.
    always_comb begin
        status_word = '0;
        status_word[0] = s_q.seen;
        status_word[1] = s_q.last_ok;
        status_word[4:2] = s_q.last_type;
        status_word[6:5] = s_q.last_why;
        status_word[16+:LEN_W] = s_q.last_len;
    end

    assign count_word = {s_q.drop_cnt, s_q.good_cnt};

    // Read multiplexer; unmapped or misaligned addresses answer with an error.
    always_comb begin
        hit = 1'b1;
        rd_val = '0;
        unique case (paddr)
            SYS_CFG_OFF: begin
                rd_val = cfg_word;
            end
            NODE_ADDR_OFF: begin
                rd_val = addr_word;
            end
            RX_STATUS_OFF: begin
                rd_val = status_word;
            end
            RX_COUNT_OFF: begin
                rd_val = count_word;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Next state of registers, bus answer and frame judge.
    always_comb begin
        s_d = s_q;
        s_d.good = 1'b0;
        s_d.drop = 1'b0;

        // Answer is prepared in setup and presented in the first access cycle.
        s_d.pready = setup;
        // An error answer also keeps the access that follows from writing.
        s_d.pslverr = setup && !hit;
        if (setup) begin
            s_d.prdata = pwrite ? 32'h0000_0000 : rd_val;
        end

        // Writes take effect at the access edge; status and counts are read only.
        if (wr_now) begin
            if (paddr == SYS_CFG_OFF) begin
                s_d.cfg = CFG_W'(merge(cfg_word, pwdata, pstrb));
            end
            if (paddr == NODE_ADDR_OFF) begin
                {s_d.net_id, s_d.short_addr} = merge(addr_word, pwdata, pstrb);
            end
        end

        // The frame is judged in the cycle after its last octet.
        unique case (s_q.state)
            ST_WAIT: begin
                if (rx_valid && rx_last) begin
                    s_d.state = ST_JUDGE;
                end
            end
            ST_JUDGE: begin
                // Status and reason hold this verdict until the next one.
                s_d.seen = 1'b1;
                s_d.last_ok = accept;
                s_d.last_type = ftype;
                s_d.last_why = why;
                s_d.last_len = count;
                s_d.why = why;

                if (accept) begin
                    s_d.good = 1'b1;
                    s_d.good_cnt = s_q.good_cnt + CNT_W'(1);
                end else begin
                    s_d.drop = 1'b1; // R18
                    s_d.drop_cnt = s_q.drop_cnt + CNT_W'(1);
                end

                // A frame ending right now is judged in the next cycle too.
                if (!(rx_valid && rx_last)) begin
                    s_d.state = ST_WAIT;
                end
            end
        endcase
    end

    // State register; identifiers come out of reset as all ones.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.cfg <= SYS_CFG_RST;
            s_q.net_id <= NET_ID_RST; // R16
            s_q.short_addr <= SHORT_ADDR_RST; // R16
            s_q.state <= ST_WAIT;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register.
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign rx_good = s_q.good;
    assign rx_drop = s_q.drop;
    assign rx_drop_why = s_q.why;
endmodule : rff_frame_filter
`default_nettype wire

// file: rff_pkg.sv
// Shared constants, types and helpers of the receive frame type filter.
// Assumes an APB slave with 12-bit byte addresses and 32-bit data.
package rff_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] SYS_CFG_OFF = 12'h004;
    localparam logic [11:0] NODE_ADDR_OFF = 12'h008;
    localparam logic [11:0] RX_STATUS_OFF = 12'h00c;
    localparam logic [11:0] RX_COUNT_OFF = 12'h010;
    localparam int unsigned CFG_W = 9;
    localparam int unsigned CFG_EN = 0;
    localparam int unsigned CFG_COORD = 1;
    localparam int unsigned CFG_BCN = 2;
    localparam int unsigned CFG_DATA = 3;
    localparam int unsigned CFG_ACK = 4;
    localparam int unsigned CFG_CMD = 5;
    localparam int unsigned CFG_RES = 6;
    localparam int unsigned CFG_T4 = 7;
    localparam int unsigned CFG_T5 = 8;
    localparam logic [8:0] SYS_CFG_RST = 9'h000;
    localparam logic [15:0] NET_ID_RST = 16'hffff;
    localparam logic [15:0] SHORT_ADDR_RST = 16'hffff;
    localparam logic [15:0] BCAST = 16'hffff;
    localparam logic [2:0] FT_BEACON = 3'h0;
    localparam logic [2:0] FT_DATA = 3'h1;
    localparam logic [2:0] FT_ACK = 3'h2;
    localparam logic [2:0] FT_CMD = 3'h3;
    localparam logic [2:0] FT_RES4 = 3'h4;
    localparam logic [2:0] FT_RES5 = 3'h5;
    localparam int unsigned FCF_PANC = 6;
    localparam int unsigned FCF_DM = 10;
    localparam int unsigned FCF_SM = 14;
    localparam logic [1:0] AM_NONE = 2'h0;
    localparam logic [1:0] AM_SHORT = 2'h2;
    localparam logic [1:0] AM_LONG = 2'h3;
    localparam logic [7:0] HDR_FIXED = 8'h03;
    localparam logic [7:0] FCS_LEN = 8'h02;
    localparam logic [7:0] PAN_LEN = 8'h02;
    localparam logic [7:0] SHORT_LEN = 8'h02;
    localparam logic [7:0] LONG_LEN = 8'h08;
    localparam logic [7:0] DST_PAN_POS = 8'h03;
    localparam logic [7:0] DST_ADDR_POS = 8'h05;
    localparam logic [1:0] WHY_NONE = 2'h0;
    localparam logic [1:0] WHY_TYPE = 2'h1;
    localparam logic [1:0] WHY_ADDR = 2'h2;
    localparam logic [1:0] WHY_LEN = 2'h3;

    typedef enum logic {ST_WAIT, ST_JUDGE} rff_judge_t;

    // Octets taken by an address of the given addressing mode.
    function automatic logic [7:0] addr_len(input logic [1:0] mode);
        addr_len = (mode == AM_SHORT) ? SHORT_LEN : (mode == AM_LONG) ? LONG_LEN : 8'h00;
    endfunction : addr_len

    // Position of the source network identifier within the frame.
    function automatic logic [7:0] src_pan_pos(input logic [15:0] fcf);
        src_pan_pos = HDR_FIXED;
        if (fcf[FCF_DM+1]) begin
            src_pan_pos = HDR_FIXED + PAN_LEN + addr_len(fcf[FCF_DM+:2]);
        end
    endfunction : src_pan_pos
endpackage : rff_pkg

// file: rff_hdr_parse.sv
// Header field capture for the receive frame type filter.
// Assumes one octet per rx_valid cycle on pclk, rx_last on the final octet.
`timescale 1ns/1ps
`default_nettype none
module rff_hdr_parse #(
    parameter int unsigned LEN_W = 11
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic [15:0] fcf,
    output logic [15:0] dst_pan,
    output logic [15:0] dst_short,
    output logic [15:0] src_pan,
    output logic [LEN_W-1:0] count
);
    import rff_pkg::*;

    typedef struct packed {
        logic [15:0] fcf;
        logic [15:0] dst_pan;
        logic [15:0] dst_short;
        logic [15:0] src_pan;
        logic [LEN_W-1:0] count;
        logic done;
    } rff_parse_t;

    rff_parse_t s_q;
    rff_parse_t s_d;
    logic [LEN_W-1:0] idx;
    logic [LEN_W-1:0] sp;

    // Each octet lands in the field its position selects; a new frame restarts at zero.
    always_comb begin
        s_d = s_q;
        idx = s_q.done ? '0 : s_q.count;
        sp = LEN_W'(src_pan_pos(s_q.fcf));
        if (rx_valid) begin
            if (idx == '0) begin
                s_d = '0;
                s_d.fcf[7:0] = rx_data;
            end
            if (idx == LEN_W'(1)) s_d.fcf[15:8] = rx_data;
            if (idx == LEN_W'(DST_PAN_POS)) s_d.dst_pan[7:0] = rx_data;
            if (idx == LEN_W'(DST_PAN_POS) + LEN_W'(1)) s_d.dst_pan[15:8] = rx_data;
            if (idx == LEN_W'(DST_ADDR_POS)) s_d.dst_short[7:0] = rx_data;
            if (idx == LEN_W'(DST_ADDR_POS) + LEN_W'(1)) s_d.dst_short[15:8] = rx_data;
            if (idx == sp) s_d.src_pan[7:0] = rx_data;
            if (idx == sp + LEN_W'(1)) s_d.src_pan[15:8] = rx_data;
            s_d.count = (&idx) ? idx : idx + LEN_W'(1);
            s_d.done = rx_last;
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{done: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign fcf = s_q.fcf;
    assign dst_pan = s_q.dst_pan;
    assign dst_short = s_q.dst_short;
    assign src_pan = s_q.src_pan;
    assign count = s_q.count;
endmodule : rff_hdr_parse
`default_nettype wire

// file: rff_chk.sv
// Checker of the receive frame type filter, watching only its top ports.
// Assumes one pclk domain with presetn as asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module rff_chk #(
    parameter int unsigned LEN_W = 11,
    parameter int unsigned CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_valid,
    input wire logic rx_last,
    input wire logic rx_good,
    input wire logic rx_drop,
    input wire logic [1:0] rx_drop_why
);
    import rff_pkg::*;
    logic last_w;
    // Final octet strobe, kept as a plain signal so it can be looked back on.
    assign last_w = rx_valid && rx_last;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_last; rx_valid && rx_last; endsequence
    sequence s_verdict; rx_good || rx_drop; endsequence
    sequence s_setup; psel && !penable; endsequence
    AST_VERDICT_AT_TWO: assert property (s_last |-> ##2 s_verdict)
        else $error("no verdict two cycles after a final octet");
    AST_NO_STRAY: assert property (s_verdict |-> $past(last_w, 2))
        else $error("verdict without a final octet");
    AST_EXCL: assert property (not (rx_good && rx_drop))
        else $error("frame both accepted and discarded");
    AST_GOOD_WHY: assert property (rx_good |-> rx_drop_why == WHY_NONE)
        else $error("accepted frame carries a reason");
    AST_DROP_WHY: assert property (rx_drop |-> rx_drop_why != WHY_NONE)
        else $error("discarded frame carries no reason");
    AST_WHY_HOLD: assert property (!(rx_good || rx_drop) |-> $stable(rx_drop_why))
        else $error("reason changed without a verdict");
    AST_APB_READY: assert property (s_setup |=> pready && psel && penable)
        else $error("no ready in the first access cycle");
    AST_APB_ONLY: assert property (pready |-> psel && penable && $past(psel) && !$past(penable))
        else $error("ready outside the first access cycle");
    AST_ERR_DATA: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response with data or without ready");
endmodule : rff_chk
bind rff_frame_filter rff_chk #(.LEN_W(LEN_W), .CNT_W(CNT_W)) rff_chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_last(rx_last), .rx_good(rx_good), .rx_drop(rx_drop), .rx_drop_why(rx_drop_why));
`default_nettype wire

// file: rff_rx_node.sv
// Model of a remote node sending frame octets to the receive filter.
// Assumes the filter takes an octet at each rising pclk edge with rx_valid high.
`timescale 1ns/1ps
`default_nettype none
module rff_rx_node (
    input wire logic pclk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last
);
    // Idle stream at time zero.
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
    end
    // Sends n octets with gap idle cycles between them; idle data is inverted so it is never stale.
    task automatic send(input logic [7:0] b [$], input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            rx_valid <= 1'b1;
            rx_data <= b[i];
            rx_last <= (i == n - 1);
            for (int g = 0; g < gap && i < n - 1; g++) begin
                @(posedge pclk);
                rx_valid <= 1'b0;
                rx_data <= ~b[i];
            end
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_data <= ~rx_data;
    endtask : send
endmodule : rff_rx_node
`default_nettype wire

// file: testbench.sv
// Self-checking testbench of the receive frame type filter.
// Assumes zero-wait APB answers and a verdict two edges after the final octet.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rff_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic rx_valid, rx_last, rx_good, rx_drop;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [7:0] rx_data;
    logic [1:0] rx_drop_why;
    int err_total, tests_run, cyc, slow;
    rff_frame_filter rff_frame_filter_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_good(rx_good),
        .rx_drop(rx_drop), .rx_drop_why(rx_drop_why));
    rff_rx_node rff_rx_node_i (.pclk(pclk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last));
    // Clock of 10 ns period.
    always #5 pclk = ~pclk;
    // Counts cycles and ends a hung run.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer, held until ready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        chk({31'h0, pready}, 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
    endtask : wr
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, eerr});
    endtask : rdchk
    // Builds a frame from its control fields, sends it less cut octets and judges the verdict.
    task automatic frm(input logic [2:0] t, input logic [1:0] dm, input logic [1:0] sm, input logic pc,
                       input logic [15:0] dpan, input logic [15:0] dst, input logic [15:0] span, input int cut,
                       input logic [1:0] why);
        logic [7:0] q [$];
        logic [15:0] f;
        int k;
        f = {sm, 2'h0, dm, 3'h0, pc, 3'h0, t};
        q = {f[7:0], f[15:8], 8'h5a};
        if (dm == AM_SHORT)
            q = {q, dpan[7:0], dpan[15:8], dst[7:0], dst[15:8]};
        if (sm == AM_SHORT && !(pc && dm == AM_SHORT))
            q = {q, span[7:0], span[15:8]};
        if (sm == AM_SHORT)
            q = {q, 8'h21, 8'h43};
        q = {q, 8'hc1, 8'hc2};
        rff_rx_node_i.send(q, q.size() - cut, slow);
        k = 0;
        do begin
            @(negedge pclk);
            k++;
        end while (rx_good !== 1'b1 && rx_drop !== 1'b1 && k < 12);
        chk({28'h0, rx_good, rx_drop, rx_drop_why}, {28'h0, why == WHY_NONE, why != WHY_NONE, why});
    endtask : frm
    task automatic t_reset();
        rdchk(SYS_CFG_OFF, 32'h0, 1'b0);
        rdchk(NODE_ADDR_OFF, 32'hffff_ffff, 1'b0);
        rdchk(12'h020, 32'h0, 1'b1);
        $display("test reset done");
    endtask : t_reset
    task automatic t_off();
        wr(SYS_CFG_OFF, 32'h2);
        frm(FT_DATA, AM_SHORT, AM_NONE, 1'b0, 16'h0bad, 16'h0bad, 16'h0, 0, WHY_NONE);
        frm(FT_ACK, AM_NONE, AM_NONE, 1'b0, 16'h0, 16'h0, 16'h0, 3, WHY_NONE);
        $display("test filter off done");
    endtask : t_off
    task automatic t_types();
        wr(NODE_ADDR_OFF, 32'h1234_5678);
        for (int t = 0; t < 4; t++) begin
            wr(SYS_CFG_OFF, 32'h1 | (32'h4 << t));
            frm(3'(t), AM_SHORT, AM_SHORT, 1'b1, 16'h1234, 16'h5678, 16'h0, 0, WHY_NONE);
            frm(3'((t + 1) % 4), AM_SHORT, AM_SHORT, 1'b1, 16'h1234, 16'h5678, 16'h0, 0, WHY_TYPE);
        end
        $display("test known types done");
    endtask : t_types
    task automatic t_addr();
        wr(SYS_CFG_OFF, 32'h9);
        slow = 1;
        frm(FT_DATA, AM_SHORT, AM_SHORT, 1'b1, 16'h1234, 16'h5679, 16'h0, 0, WHY_ADDR);
        slow = 0;
        frm(FT_DATA, AM_SHORT, AM_SHORT, 1'b1, 16'h1235, 16'h5678, 16'h0, 0, WHY_ADDR);
        frm(FT_DATA, AM_SHORT, AM_SHORT, 1'b1, 16'h1234, BCAST, 16'h0, 0, WHY_NONE);
        $display("test address done");
    endtask : t_addr
    task automatic t_coord();
        wr(SYS_CFG_OFF, 32'hb);
        frm(FT_DATA, AM_NONE, AM_SHORT, 1'b0, 16'h0, 16'h0, 16'h1234, 0, WHY_NONE);
        frm(FT_DATA, AM_NONE, AM_SHORT, 1'b0, 16'h0, 16'h0, 16'h4321, 0, WHY_ADDR);
        wr(SYS_CFG_OFF, 32'h9);
        frm(FT_DATA, AM_NONE, AM_SHORT, 1'b0, 16'h0, 16'h0, 16'h1234, 0, WHY_ADDR);
        wr(SYS_CFG_OFF, 32'h5);
        frm(FT_BEACON, AM_NONE, AM_SHORT, 1'b0, 16'h0, 16'h0, 16'h1234, 0, WHY_NONE);
        $display("test coordinator done");
    endtask : t_coord
    task automatic t_res();
        wr(SYS_CFG_OFF, 32'h41);
        for (int t = 4; t < 8; t++) begin
            frm(3'(t), AM_SHORT, AM_NONE, 1'b0, 16'h0bad, 16'h0bad, 16'h0, 0, WHY_NONE);
        end
        wr(SYS_CFG_OFF, 32'h81);
        frm(FT_RES4, AM_SHORT, AM_NONE, 1'b0, 16'h0bad, 16'h0bad, 16'h0, 0, WHY_NONE);
        frm(FT_RES5, AM_NONE, AM_NONE, 1'b0, 16'h0, 16'h0, 16'h0, 0, WHY_TYPE);
        frm(FT_RES4, AM_SHORT, AM_NONE, 1'b0, 16'h0bad, 16'h0bad, 16'h0, 1, WHY_LEN);
        wr(SYS_CFG_OFF, 32'h101);
        frm(FT_RES5, AM_SHORT, AM_NONE, 1'b0, 16'h0bad, 16'h0bad, 16'h0, 0, WHY_NONE);
        frm(FT_RES4, AM_NONE, AM_NONE, 1'b0, 16'h0, 16'h0, 16'h0, 0, WHY_TYPE);
        wr(SYS_CFG_OFF, 32'h1);
        frm(3'h6, AM_NONE, AM_NONE, 1'b0, 16'h0, 16'h0, 16'h0, 0, WHY_TYPE);
        wr(SYS_CFG_OFF, 32'h9);
        frm(FT_DATA, AM_SHORT, AM_SHORT, 1'b1, 16'h1234, 16'h5678, 16'h0, 1, WHY_LEN);
        rdchk(RX_STATUS_OFF, 32'h000a_0065, 1'b0);
        $display("test reserved and length done");
    endtask : t_res
    // Reset for six cycles, then the scenarios in turn.
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        err_total = 0;
        tests_run = 0;
        cyc = 0;
        slow = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_off();
        t_types();
        t_addr();
        t_coord();
        t_res();
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
